/* File: src/can_accept_cfg.svh */
`ifndef CAN_ACCEPT_CFG_SVH
`define CAN_ACCEPT_CFG_SVH

`define OFS_FILTER_ENABLE 12'h000
`define OFS_BUF_PTR0 12'h004
`define OFS_MASK_SEL_LOW 12'h014
`define OFS_MASK_SEL_HIGH 12'h018
`define OFS_MASK_SID0 12'h01c
`define OFS_MASK_EID0 12'h028
`define OFS_RX_FULL_LOW 12'h034
`define OFS_RX_FULL_HIGH 12'h038
`define OFS_RX_OVF_LOW 12'h03c
`define OFS_RX_OVF_HIGH 12'h040
`define OFS_IRQ_STATUS 12'h044
`define OFS_IRQ_ENABLE 12'h048
`define OFS_IRQ_CLEAR 12'h04c
`define OFS_FILTER_SID0 12'h100
`define OFS_FILTER_EID0 12'h140

`define RST_FILTER_ENABLE 16'hffff
`define RST_ZERO16 16'h0000
`define MASK_SID_IMPL 16'hffeb
`define POS_ID_MODE 3
`define PTR_FIFO 4'hf
`define SEL_RESERVED 2'h3
`define LAST_FILTER 4'hf
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/can_accept_pkg.sv */
package can_accept_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_CHECK = 2'b10
  } scan_state_t;

  typedef enum logic [1:0] {
    EVT_STORED = 2'b00,
    EVT_OVERFLOW = 2'b01,
    EVT_REJECTED = 2'b10
  } irq_bit_t;

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] be);
    merge16 = (old_v & ~lane_mask(be)) | (new_v & lane_mask(be));
  endfunction

endpackage

/* File: src/can_filter_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module can_filter_mem (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [3:0] i_waddr,
  input wire logic [1:0] i_be,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_raddr_a,
  output logic [15:0] o_rdata_a,
  input wire logic [3:0] i_raddr_b,
  output logic [15:0] o_rdata_b
);
  // contents are undefined after reset, software programs every filter it enables
  logic [15:0] mem_q [16];

  always_ff @(posedge i_mclk)
  begin
    if (i_we && i_be[0])
    begin
      mem_q[i_waddr][7:0] <= i_wdata[7:0];
    end
    if (i_we && i_be[1])
    begin
      mem_q[i_waddr][15:8] <= i_wdata[15:8];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata_a <= 16'h0000;
      o_rdata_b <= 16'h0000;
    end
    else
    begin
      o_rdata_a <= mem_q[i_raddr_a];
      o_rdata_b <= mem_q[i_raddr_b];
    end
  end
endmodule // can_filter_mem
`default_nettype wire

/* File: src/can_filter_match.sv */
`timescale 1ns/10ps
`default_nettype none
module can_filter_match (
  input wire logic [15:0] i_filt_sid,
  input wire logic [15:0] i_filt_eid,
  input wire logic [15:0] i_mask_sid,
  input wire logic [15:0] i_mask_eid,
  input wire logic [10:0] i_msg_sid,
  input wire logic [17:0] i_msg_eid,
  input wire logic i_msg_ext,
  output logic o_hit
);
  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  // compare only bits the mask includes
  assign sid_ok = ((i_filt_sid[15:5] ^ i_msg_sid) & i_mask_sid[15:5]) == 11'h000;
  assign eid_ok = (({i_filt_sid[1:0], i_filt_eid} ^ i_msg_eid)
                   & {i_mask_sid[1:0], i_mask_eid}) == 18'h00000;
  // filter type bit only counts in strict mode
  assign type_ok = !i_mask_sid[3] || (i_filt_sid[3] == i_msg_ext);
  // standard frames carry no extended part
  assign o_hit = type_ok && sid_ok && (!i_msg_ext || eid_ok);
endmodule // can_filter_match
`default_nettype wire

/* File: src/can_accept_filter.sv */
// Behaviour
// - filter extended word: each bit demands the same message extended id bit
// - two-bit mask source per filter picks mask 0, 1 or 2; 11 reserved
// - filters 7..0 mask sources in select-low register, filter 7 at top
// - filters 15..8 mask sources in select-high register, filter 15 at top
// - standard mask bit set compares that id bit, clear ignores it
// - eighteen extended mask bits include or exclude their id bit
// - strict mode bit: frame type must agree with filter extended select
// - relaxed mode: standard frames match on sid, extended on full id
// - thirty-two buffer-full flags in two registers, set when a buffer is stored
// - overflow flag set when accepted message targets a still-full buffer
// - mask standard word bits 4 and 2 always read zero
// - filter standard id bits must equal message standard id bits
// - filter extended select picks extended or standard frames in strict mode
// - filter takes part only while enabled; enables reset to all ones
// - four-bit pointer per filter: buffers 0..14, all ones means fifo
`timescale 1ns/10ps
`default_nettype none
`include "can_accept_cfg.svh"
module can_accept_filter
  import can_accept_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [11:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [11:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_msg_valid,
  output logic o_msg_ready,
  input wire logic [10:0] i_msg_sid,
  input wire logic [17:0] i_msg_eid,
  input wire logic i_msg_ext,
  input wire logic [4:0] i_msg_fifo_slot,
  output logic o_rx_done,
  output logic o_rx_hit,
  output logic [3:0] o_rx_filter,
  output logic [4:0] o_rx_buffer,
  output logic o_rx_overflow,
  output logic o_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  function automatic logic in_region(input logic [11:0] a, input logic [11:0] base);
    in_region = (a[11:6] == base[11:6]);
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a[1:0] == 2'h0) && ((a <= `OFS_IRQ_CLEAR) || in_region(a, `OFS_FILTER_SID0)
                 || in_region(a, `OFS_FILTER_EID0));
  endfunction

  logic aw_held_q;
  logic w_held_q;
  logic [11:0] aw_addr_q;
  logic [15:0] w_data_q;
  logic [1:0] w_be_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic [1:0] rd_stage_q;
  logic [11:0] ar_addr_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic [15:0] rd_mux;

  logic [15:0] en_q;
  logic [15:0] ptr_q [4];
  logic [15:0] sel_q [2];
  logic [15:0] msid_q [3];
  logic [15:0] meid_q [3];
  logic [31:0] full_q;
  logic [31:0] ovf_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_en_q;

  scan_state_t state_q;
  logic [3:0] idx_q;
  logic [10:0] msg_sid_q;
  logic [17:0] msg_eid_q;
  logic msg_ext_q;
  logic [4:0] slot_q;
  logic [15:0] fsid_bus, feid_bus, fsid_scan, feid_scan;
  logic [1:0] sel;
  logic [15:0] mask_sid, mask_eid;
  logic id_hit, cand_hit, fin, fin_hit, tgt_full;
  logic [3:0] ptr;
  logic [4:0] tgt;
  logic [31:0] clr_full, clr_ovf, set_full, set_ovf;
  logic [2:0] irq_evt;

  // write channel: address and data taken in either order, one write in flight
  assign o_s_axi_awready = !aw_held_q && !bvalid_q;
  assign o_s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 16'h0000;
      w_be_q <= 2'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= i_s_axi_wdata[15:0];
        w_be_q <= i_s_axi_wstrb[1:0];
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_known(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q && i_s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers; unknown-at-power-up fields start at zero here
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      en_q <= `RST_FILTER_ENABLE;
      irq_en_q <= 3'h0;
      for (int k = 0; k < 4; k++) ptr_q[k] <= `RST_ZERO16;
      for (int k = 0; k < 2; k++) sel_q[k] <= `RST_ZERO16;
      for (int k = 0; k < 3; k++)
      begin
        msid_q[k] <= `RST_ZERO16;
        meid_q[k] <= `RST_ZERO16;
      end
    end
    else if (wr_fire)
    begin
      if (aw_addr_q == `OFS_FILTER_ENABLE) en_q <= merge16(en_q, w_data_q, w_be_q);
      if (aw_addr_q == `OFS_IRQ_ENABLE) irq_en_q <= w_be_q[0] ? w_data_q[2:0] : irq_en_q;
      for (int k = 0; k < 4; k++)
        if (aw_addr_q == `OFS_BUF_PTR0 + 12'(4 * k)) ptr_q[k] <= merge16(ptr_q[k], w_data_q, w_be_q);
      if (aw_addr_q == `OFS_MASK_SEL_LOW) sel_q[0] <= merge16(sel_q[0], w_data_q, w_be_q);
      if (aw_addr_q == `OFS_MASK_SEL_HIGH) sel_q[1] <= merge16(sel_q[1], w_data_q, w_be_q);
      for (int k = 0; k < 3; k++)
      begin
        if (aw_addr_q == `OFS_MASK_SID0 + 12'(4 * k))
          msid_q[k] <= merge16(msid_q[k], w_data_q, w_be_q) & `MASK_SID_IMPL;
        if (aw_addr_q == `OFS_MASK_EID0 + 12'(4 * k))
          meid_q[k] <= merge16(meid_q[k], w_data_q, w_be_q);
      end
    end
  end

  // filter identifier words; the scan port and the bus port read independently
  can_filter_mem u_sid_mem (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_we(wr_fire && in_region(aw_addr_q, `OFS_FILTER_SID0)),
    .i_waddr(aw_addr_q[5:2]),
    .i_be(w_be_q),
    .i_wdata(w_data_q & `MASK_SID_IMPL),
    .i_raddr_a(ar_addr_q[5:2]),
    .o_rdata_a(fsid_bus),
    .i_raddr_b(idx_q),
    .o_rdata_b(fsid_scan)
  );

  can_filter_mem u_eid_mem (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_we(wr_fire && in_region(aw_addr_q, `OFS_FILTER_EID0)),
    .i_waddr(aw_addr_q[5:2]),
    .i_be(w_be_q),
    .i_wdata(w_data_q),
    .i_raddr_a(ar_addr_q[5:2]),
    .o_rdata_a(feid_bus),
    .i_raddr_b(idx_q),
    .o_rdata_b(feid_scan)
  );

  // read channel: two cycles so the memory output settles before rdata is latched
  assign o_s_axi_arready = (rd_stage_q == 2'h0) && !rvalid_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;

  always_comb
  begin
    rd_mux = 16'h0000;
    if (ar_addr_q == `OFS_FILTER_ENABLE) rd_mux = en_q;
    for (int k = 0; k < 4; k++)
      if (ar_addr_q == `OFS_BUF_PTR0 + 12'(4 * k)) rd_mux = ptr_q[k];
    if (ar_addr_q == `OFS_MASK_SEL_LOW) rd_mux = sel_q[0];
    if (ar_addr_q == `OFS_MASK_SEL_HIGH) rd_mux = sel_q[1];
    for (int k = 0; k < 3; k++)
    begin
      if (ar_addr_q == `OFS_MASK_SID0 + 12'(4 * k)) rd_mux = msid_q[k];
      if (ar_addr_q == `OFS_MASK_EID0 + 12'(4 * k)) rd_mux = meid_q[k];
    end
    if (ar_addr_q == `OFS_RX_FULL_LOW) rd_mux = full_q[15:0];
    if (ar_addr_q == `OFS_RX_FULL_HIGH) rd_mux = full_q[31:16];
    if (ar_addr_q == `OFS_RX_OVF_LOW) rd_mux = ovf_q[15:0];
    if (ar_addr_q == `OFS_RX_OVF_HIGH) rd_mux = ovf_q[31:16];
    if (ar_addr_q == `OFS_IRQ_STATUS) rd_mux = {13'h0000, irq_st_q};
    if (ar_addr_q == `OFS_IRQ_ENABLE) rd_mux = {13'h0000, irq_en_q};
    if (in_region(ar_addr_q, `OFS_FILTER_SID0)) rd_mux = fsid_bus;
    if (in_region(ar_addr_q, `OFS_FILTER_EID0)) rd_mux = feid_bus;
    if (!addr_known(ar_addr_q)) rd_mux = 16'h0000;
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_stage_q <= 2'h0;
      ar_addr_q <= 12'h000;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
    end
    else
    begin
      if (i_s_axi_arvalid && o_s_axi_arready)
      begin
        ar_addr_q <= i_s_axi_araddr;
        rd_stage_q <= 2'h1;
      end
      else if (rd_stage_q == 2'h1)
      begin
        rd_stage_q <= 2'h2;
      end
      else if (rd_stage_q == 2'h2)
      begin
        rd_stage_q <= 2'h0;
        rvalid_q <= 1'b1;
        rdata_q <= {16'h0000, rd_mux};
        rresp_q <= addr_known(ar_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && i_s_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // scan filters one by one from 0 upward, so the first hit is the lowest number
  assign o_msg_ready = (state_q == ST_IDLE);
  assign sel = sel_q[idx_q[3]][{idx_q[2:0], 1'b0} +: 2];

  always_comb
  begin
    mask_sid = 16'h0000;
    mask_eid = 16'h0000;
    unique case (sel)
      2'h0: begin mask_sid = msid_q[0]; mask_eid = meid_q[0]; end
      2'h1: begin mask_sid = msid_q[1]; mask_eid = meid_q[1]; end
      2'h2: begin mask_sid = msid_q[2]; mask_eid = meid_q[2]; end
      2'h3: begin mask_sid = 16'h0000; mask_eid = 16'h0000; end
    endcase
  end

  can_filter_match u_match (
    .i_filt_sid(fsid_scan),
    .i_filt_eid(feid_scan),
    .i_mask_sid(mask_sid),
    .i_mask_eid(mask_eid),
    .i_msg_sid(msg_sid_q),
    .i_msg_eid(msg_eid_q),
    .i_msg_ext(msg_ext_q),
    .o_hit(id_hit)
  );

  // a reserved selector never matches rather than guessing a mask
  assign cand_hit = (state_q == ST_CHECK) && en_q[idx_q] && (sel != `SEL_RESERVED) && id_hit;
  assign fin = (state_q == ST_CHECK) && (cand_hit || idx_q == `LAST_FILTER);
  assign fin_hit = fin && cand_hit;
  assign ptr = ptr_q[idx_q[3:2]][{idx_q[1:0], 2'h0} +: 4];
  assign tgt = (ptr == `PTR_FIFO) ? slot_q : {1'b0, ptr};
  assign tgt_full = full_q[tgt];

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
      msg_sid_q <= 11'h000;
      msg_eid_q <= 18'h00000;
      msg_ext_q <= 1'b0;
      slot_q <= 5'h00;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (i_msg_valid)
          begin
            msg_sid_q <= i_msg_sid;
            msg_eid_q <= i_msg_eid;
            msg_ext_q <= i_msg_ext;
            slot_q <= i_msg_fifo_slot;
            idx_q <= 4'h0;
            state_q <= ST_READ;
          end
        ST_READ:
          state_q <= ST_CHECK;
        ST_CHECK:
          if (fin)
          begin
            state_q <= ST_IDLE;
          end
          else
          begin
            idx_q <= idx_q + 4'h1;
            state_q <= ST_READ;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rx_done <= 1'b0;
      o_rx_hit <= 1'b0;
      o_rx_filter <= 4'h0;
      o_rx_buffer <= 5'h00;
      o_rx_overflow <= 1'b0;
    end
    else
    begin
      o_rx_done <= fin;
      if (fin)
      begin
        o_rx_hit <= cand_hit;
        o_rx_filter <= idx_q;
        o_rx_buffer <= cand_hit ? tgt : 5'h00;
        o_rx_overflow <= fin_hit && tgt_full;
      end
    end
  end

  // flag registers: software can only clear (written zero), the module only sets
  assign set_full = (fin_hit && !tgt_full) ? (32'h00000001 << tgt) : 32'h00000000;
  assign set_ovf = (fin_hit && tgt_full) ? (32'h00000001 << tgt) : 32'h00000000;
  assign clr_full = !wr_fire ? 32'h00000000 :
                    (aw_addr_q == `OFS_RX_FULL_LOW) ? {16'h0000, ~w_data_q & lane_mask(w_be_q)} :
                    (aw_addr_q == `OFS_RX_FULL_HIGH) ? {~w_data_q & lane_mask(w_be_q), 16'h0000} :
                    32'h00000000;
  assign clr_ovf = !wr_fire ? 32'h00000000 :
                   (aw_addr_q == `OFS_RX_OVF_LOW) ? {16'h0000, ~w_data_q & lane_mask(w_be_q)} :
                   (aw_addr_q == `OFS_RX_OVF_HIGH) ? {~w_data_q & lane_mask(w_be_q), 16'h0000} :
                   32'h00000000;

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      full_q <= 32'h00000000;
      ovf_q <= 32'h00000000;
    end
    else
    begin
      // a set in the same cycle as a clear wins
      full_q <= (full_q & ~clr_full) | set_full;
      ovf_q <= (ovf_q & ~clr_ovf) | set_ovf;
    end
  end

  assign irq_evt = {fin && !cand_hit, fin_hit && tgt_full, fin_hit && !tgt_full};

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_st_q <= 3'h0;
    end
    else if (wr_fire && aw_addr_q == `OFS_IRQ_CLEAR && w_be_q[0])
    begin
      irq_st_q <= (irq_st_q & ~w_data_q[2:0]) | irq_evt;
    end
    else
    begin
      irq_st_q <= irq_st_q | irq_evt;
    end
  end

  assign o_irq = |(irq_st_q & irq_en_q);

  sequence s_msg_taken;
    i_msg_valid && o_msg_ready;
  endsequence

  sequence s_scan_over;
    o_rx_done && o_msg_ready;
  endsequence

  // no hit means all sixteen filters were checked: done lands on cycle 33
  a_scan_bounded: assert property (s_msg_taken |-> ##[3:33] s_scan_over)
    else $error("scan did not finish within 33 cycles");
  a_enable_reset: assert property ($rose(i_resetn) |-> en_q == 16'hffff)
    else $error("filter enables not all set after reset");
  a_hit_enabled: assert property (o_rx_done && o_rx_hit |-> $past(en_q[idx_q]))
    else $error("disabled filter reported a hit");
  a_reserved_select: assert property (state_q == ST_CHECK && sel == 2'h3 |-> !cand_hit)
    else $error("reserved mask source produced a match");
  a_store_sets_full: assert property (o_rx_done && o_rx_hit && !o_rx_overflow |-> full_q[o_rx_buffer])
    else $error("stored buffer has no full flag");
  a_overflow_flag: assert property (o_rx_done && o_rx_overflow |-> ovf_q[o_rx_buffer] && full_q[o_rx_buffer])
    else $error("overflow not flagged on full buffer");
  a_full_rise_cause: assert property (|(full_q & ~$past(full_q)) |-> $past(fin_hit))
    else $error("full flag rose without a stored message");
  a_ovf_fall_cause: assert property (|($past(ovf_q) & ~ovf_q) |-> $past(wr_fire))
    else $error("overflow flag cleared without a bus write");
  a_mask_zero_bits: assert property (((msid_q[0] | msid_q[1] | msid_q[2]) & 16'h0014) == 16'h0000)
    else $error("unimplemented mask bits hold ones");
endmodule // can_accept_filter
`default_nettype wire

/* File: dv/can_msg_source.sv */
`timescale 1ns/10ps
`default_nettype none
module can_msg_source (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_go,
  input wire logic [10:0] i_sid,
  input wire logic [17:0] i_eid,
  input wire logic i_ext,
  input wire logic [4:0] i_slot,
  input wire logic i_ready,
  output logic o_valid,
  output logic [10:0] o_sid,
  output logic [17:0] o_eid,
  output logic o_ext,
  output logic [4:0] o_slot
);
  // between frames the id lines show the inverse, so a stale id never matches by luck
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_valid <= 1'b0;
      {o_sid, o_eid, o_ext, o_slot} <= '0;
    end
    else if (i_go)
    begin
      o_valid <= 1'b1;
      {o_sid, o_eid, o_ext, o_slot} <= {i_sid, i_eid, i_ext, i_slot};
    end
    else if (o_valid && i_ready)
    begin
      o_valid <= 1'b0;
      {o_sid, o_eid, o_ext, o_slot} <= ~{o_sid, o_eid, o_ext, o_slot};
    end
  end
endmodule // can_msg_source
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "can_accept_cfg.svh"
module tb;
  logic i_mclk, i_resetn, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, seed, full, ovf;
  logic [1:0] bresp, rresp;
  logic go, mv, mr, mx, gx, done, hit, ovo, irq;
  logic [10:0] ms_id, gs;
  logic [17:0] me_id, ge;
  logic [4:0] msl, gsl, obuf;
  logic [3:0] ofl;
  logic [15:0] fs[16], fe[16], ms[3], me[3], en, slo, shi;
  logic [3:0] ptr[16];
  logic [2:0] ist, ien;
  int n_mismatch = 0, checks = 0, cyc = 0;

  can_accept_filter dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'h3), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
    .i_msg_valid(mv), .o_msg_ready(mr), .i_msg_sid(ms_id), .i_msg_eid(me_id), .i_msg_ext(mx),
    .i_msg_fifo_slot(msl), .o_rx_done(done), .o_rx_hit(hit), .o_rx_filter(ofl),
    .o_rx_buffer(obuf), .o_rx_overflow(ovo), .o_irq(irq));

  can_msg_source src (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_go(go), .i_sid(gs), .i_eid(ge),
    .i_ext(gx), .i_slot(gsl), .i_ready(mr), .o_valid(mv), .o_sid(ms_id), .o_eid(me_id),
    .o_ext(mx), .o_slot(msl));

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // each task starts one edge late so a strobe is never lowered and raised in one step
  // handshakes are judged on values settled before the edge, never on what that edge launches
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] g;
    @(posedge i_mclk);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(negedge i_mclk);
      ah = awv && awr;
      wh = wv && wr_r;
      bh = (bv === 1'b1);
      g = bresp;
      @(posedge i_mclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end while (!bh);
    br <= 1'b0;
    chk(g, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    logic ah, bh;
    logic [1:0] g;
    logic [31:0] d;
    @(posedge i_mclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(negedge i_mclk);
      ah = arv && arr;
      bh = (rv === 1'b1);
      g = rresp;
      d = rdat;
      @(posedge i_mclk);
      if (ah) arv <= 1'b0;
    end while (!bh);
    rr <= 1'b0;
    chk(d, {16'h0000, e});
    chk(g, er);
  endtask

  function automatic logic match(input int k, input logic [10:0] s, input logic [17:0] e, input logic x);
    logic [15:0] m;
    logic [1:0] q;
    q = (k < 8) ? slo[2*k +: 2] : shi[2*(k-8) +: 2];
    if (q == 2'h3) return 1'b0;
    m = ms[q];
    if (m[3] && (fs[k][3] != x)) return 1'b0;
    if (((fs[k][15:5] ^ s) & m[15:5]) != 11'h000) return 1'b0;
    if (x && ((({fs[k][1:0], fe[k]} ^ e) & {m[1:0], me[q]}) != 18'h00000)) return 1'b0;
    return 1'b1;
  endfunction

  task automatic cfg();
    logic [15:0] v;
    for (int k = 0; k < 16; k++)
    begin
      v = 16'(rnd());
      fs[k] = v & 16'hffeb;
      wr(12'(`OFS_FILTER_SID0 + 4*k), v, 2'h0);
      fe[k] = 16'(rnd());
      wr(12'(`OFS_FILTER_EID0 + 4*k), fe[k], 2'h0);
    end
    for (int r = 0; r < 4; r++)
    begin
      v = 16'(rnd());
      for (int i = 0; i < 4; i++) ptr[4*r+i] = v[4*i +: 4];
      wr(12'(`OFS_BUF_PTR0 + 4*r), v, 2'h0);
    end
    for (int m = 0; m < 3; m++)
    begin
      v = 16'(rnd());
      ms[m] = v & 16'hffeb;
      wr(12'(`OFS_MASK_SID0 + 4*m), v, 2'h0);
      me[m] = 16'(rnd());
      wr(12'(`OFS_MASK_EID0 + 4*m), me[m], 2'h0);
    end
    slo = 16'(rnd());
    shi = 16'(rnd());
    en = 16'(rnd());
    ien = 3'(rnd());
    wr(`OFS_MASK_SEL_LOW, slo, 2'h0);
    wr(`OFS_MASK_SEL_HIGH, shi, 2'h0);
    wr(`OFS_FILTER_ENABLE, en, 2'h0);
    wr(`OFS_IRQ_ENABLE, {13'h0000, ien}, 2'h0);
    rd(`OFS_MASK_SID0 + 12'h004, ms[1], 2'h0);
    rd(`OFS_MASK_SEL_HIGH, shi, 2'h0);
    rd(`OFS_FILTER_SID0 + 12'h03c, fs[15], 2'h0);
    rd(`OFS_FILTER_EID0 + 12'h03c, fe[15], 2'h0);
  endtask

  task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x, input logic [4:0] sl);
    int w;
    logic [4:0] b;
    w = 16;
    for (int j = 15; j >= 0; j--) if (en[j] && match(j, s, e, x)) w = j;
    @(posedge i_mclk);
    {gs, ge, gx, gsl} <= {s, e, x, sl};
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    // results are read between edges, where they have settled
    do
    begin
      @(negedge i_mclk);
    end while (done !== 1'b1);
    chk(hit, w < 16);
    if (w < 16)
    begin
      b = (ptr[w] == 4'hf) ? sl : {1'b0, ptr[w]};
      chk(ofl, w);
      chk(obuf, b);
      chk(ovo, full[b]);
      // an old overflow bit must not turn a fresh store into an overflow event
      ist = ist | (full[b] ? 3'h2 : 3'h1);
      if (full[b]) ovf[b] = 1'b1;
      else full[b] = 1'b1;
    end
    else ist[2] = 1'b1;
    chk(irq, |(ist & ien));
  endtask

  initial
  begin
    logic [31:0] v;
    {awa, ara, wd, awv, wv, br, arv, rr, go, gs, ge, gx, gsl} = '0;
    {full, ovf, ist} = '0;
    seed = 32'ha762cf40;
    i_resetn = 1'b0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rd(`OFS_FILTER_ENABLE, 16'hffff, 2'h0);
    rd(`OFS_MASK_SEL_LOW, 16'h0000, 2'h0);
    rd(12'h0f0, 16'h0000, 2'h2);
    wr(`OFS_RX_FULL_HIGH, 16'hffff, 2'h0);
    rd(`OFS_RX_FULL_HIGH, 16'h0000, 2'h0);
    wr(`OFS_RX_OVF_LOW, 16'hffff, 2'h0);
    rd(`OFS_RX_OVF_LOW, 16'h0000, 2'h0);
    repeat (3)
    begin
      cfg();
      for (int i = 0; i < 80; i++)
      begin
        v = rnd();
        send(fs[v[3:0]][15:5], {fs[v[3:0]][1:0], fe[v[3:0]]} ^ (v[5:4] == 2'h0 ? 18'h1 << v[12:8] : 18'h0),
             v[6], v[20:16]);
        if (i % 16 == 15)
        begin
          rd(`OFS_RX_FULL_LOW, full[15:0], 2'h0);
          rd(`OFS_RX_FULL_HIGH, full[31:16], 2'h0);
          rd(`OFS_RX_OVF_LOW, ovf[15:0], 2'h0);
          rd(`OFS_RX_OVF_HIGH, ovf[31:16], 2'h0);
          rd(`OFS_IRQ_STATUS, {13'h0000, ist}, 2'h0);
          v = rnd();
          wr(`OFS_RX_FULL_LOW, v[15:0], 2'h0);
          wr(`OFS_RX_OVF_LOW, v[31:16], 2'h0);
          full[15:0] = full[15:0] & v[15:0];
          ovf[15:0] = ovf[15:0] & v[31:16];
          wr(`OFS_IRQ_CLEAR, 16'h0007, 2'h0);
          ist = 3'h0;
          chk(irq, 1'b0);
        end
      end
    end
    end_sim();
  end
endmodule // tb
`default_nettype wire
